//--- core/cct_regs.svh
// timing constants for the core cycle timing block
`ifndef CCT_REGS_SVH
`define CCT_REGS_SVH
`define CCT_CLKS_PER_CYCLE   2'h3
`define CCT_CYC_ONE          4'h1
`define CCT_CYC_TWO          4'h2
`define CCT_CYC_THREE        4'h3
`define CCT_CYC_FOUR         4'h4
`define CCT_CYC_FIVE         4'h5
`define CCT_MOVE_BASE        4'h2
`define CCT_STRETCH_RESET    3'h1
`define CCT_SLOW_TIMER_DIV   4'hb
`define CCT_FAST_TIMER_DIV   4'h3
`define CCT_RESET_PC         16'h0000
`define CCT_OPCODE_HOLE      8'ha5
`define CCT_ALE_PHASE        2'h0
`define CCT_SCRATCH_WORDS    256
`endif

//--- core/cct_pkg.sv
// types for the core cycle timing block
package cct_pkg;
    typedef enum logic [1:0] {
        CCT_IDLE  = 2'b00,
        CCT_FETCH = 2'b01,
        CCT_EXEC  = 2'b10,
        CCT_DATA  = 2'b11
    } cct_state_t;
    typedef enum logic [2:0] {
        CCT_K_PLAIN = 3'b000,
        CCT_K_MULDIV = 3'b001,
        CCT_K_DATAMOVE = 3'b010,
        CCT_K_BRANCH = 3'b011,
        CCT_K_CODE   = 3'b100
    } cct_kind_t;
endpackage

//--- core/cct_decode.sv
// opcode to machine-cycle count decoder
`timescale 1ns/1ps
`default_nettype none
`include "cct_regs.svh"
module cct_decode (
    input  wire logic [7:0]       opcode,     // fetched opcode
    output var  logic [3:0]       cycles,     // fixed machine cycles
    output var  logic             isDataMove, // external data move
    output var  logic             isValid     // opcode implemented
);
    logic [3:0] hi;
    logic [3:0] lo;
    always_comb begin
        hi = opcode[7:4];
        lo = opcode[3:0];
        cycles = `CCT_CYC_ONE;
        isDataMove = 1'b0;
        isValid = (opcode != `CCT_OPCODE_HOLE);
        if (opcode == 8'ha4 || opcode == 8'h84) begin
            cycles = `CCT_CYC_FIVE;
        end else if (hi == 4'he || hi == 4'hf) begin
            if (lo == 4'h0 || lo == 4'h2 || lo == 4'h3) begin
                isDataMove = 1'b1;
            end else if (lo == 4'h5) begin
                cycles = `CCT_CYC_TWO;
            end
        end else if (lo == 4'h1) begin
            cycles = `CCT_CYC_THREE;
        end else if (opcode == 8'h02 || opcode == 8'h12 || opcode == 8'h22
                     || opcode == 8'h32 || hi == 4'hb && lo >= 4'h4
                     || opcode == 8'h10 || opcode == 8'h20 || opcode == 8'h30
                     || opcode == 8'hd5) begin
            cycles = `CCT_CYC_FOUR;
        end else if (opcode == 8'h80 || opcode == 8'h40 || opcode == 8'h50
                     || opcode == 8'h60 || opcode == 8'h70 || opcode == 8'h73
                     || opcode == 8'ha3 || opcode == 8'h83 || opcode == 8'h93
                     || hi == 4'hd && lo >= 4'h8) begin
            cycles = `CCT_CYC_THREE;
        end else if (opcode == 8'h85 || opcode == 8'h90 || lo == 4'h3
                     && hi >= 4'h4 && hi <= 4'h6 || opcode == 8'h75) begin
            cycles = `CCT_CYC_THREE;
        end else if (lo == 4'h4 && hi >= 4'h2 && hi <= 4'h9 || lo == 4'h5
                     || lo == 4'h2 || lo == 4'h6 && hi == 4'h8
                     || lo == 4'h7 && hi == 4'h8 || lo >= 4'h8 && hi == 4'h8
                     || hi == 4'ha && lo >= 4'h6 || hi == 4'h7 && lo >= 4'h4
                     || hi == 4'hc && (lo == 4'h0 || lo == 4'h2)
                     || hi == 4'hd && (lo == 4'h0 || lo == 4'h2)
                     || opcode == 8'ha0 || opcode == 8'hb0 || opcode == 8'h72
                     || opcode == 8'h82 || opcode == 8'ha2) begin
            cycles = `CCT_CYC_TWO;
        end
    end
endmodule
`default_nettype wire

//--- core/cct_core_timing.sv
// machine-cycle sequencer and external bus timing of the core
`timescale 1ns/1ps
`default_nettype none
`include "cct_regs.svh"
// How it works
// - each machine cycle lasts exactly four oscillator clocks
// - one address latch pulse issued per machine cycle
// - instruction results match the standard set; only timing differs
// - timers tick every 12 clocks, or every 4 when fast selected
// - most instructions spend one machine cycle per opcode byte
// - multiply and divide take five machine cycles
// - external data moves last two to nine machine cycles
// - direct-to-direct move takes three machine cycles
// - jumps, calls and returns take three or four machine cycles, except a jump or call opcode with high nibble e or f, which takes one
// - decoder accepts 255 opcodes for 111 instructions
// - no internal program memory; 256 byte scratchpad inside
// - low address driven on low port for fetches only, data moves leave it released; data on low port, high address on high port
// - program fetches never stretched
// - data accesses use the stretchable move timing
// - move length is stretch value plus two machine cycles
// - stretch value is one after reset
module cct_core_timing (
    input  wire logic        sys_clk,         // oscillator clock
    input  wire logic        rst,             // synchronous reset
    input  wire logic [7:0]  lowPortBusIn,    // low port bus pins in
    input  wire logic [2:0]  stretchIn,       // clock control stretch field
    input  wire logic        stretchWrite,    // load stretch field
    input  wire logic        timerFast,       // timers at four clocks
    input  wire logic [15:0] dataAddr,        // data move address
    input  wire logic [7:0]  scratchAddr,     // scratchpad address
    input  wire logic [7:0]  scratchWdata,    // scratchpad write data
    input  wire logic        scratchWe,       // scratchpad write
    output logic [7:0]       lowPortBusOut,   // low port bus drive
    output logic             lowPortBusOe_n,  // low port enable, low drives
    output logic [7:0]       highPortBus,     // high address byte
    output logic             addrLatch,       // address latch pulse
    output logic             progStrobe_n,    // program read strobe
    output logic             dataRead_n,      // data read strobe
    output logic             timerTick,       // timer advance pulse
    output logic [7:0]       scratchRdata,    // scratchpad read data
    output logic [7:0]       opcodeQ,         // current opcode
    output logic             illegalOp        // unimplemented opcode seen
);
    cct_pkg::cct_state_t stateQ, stateD;
    logic [1:0]  phaseQ, phaseD;
    logic [3:0]  leftQ, leftD;
    logic [15:0] pcQ, pcD;
    logic [2:0]  stretchQ, stretchD;
    logic [3:0]  tdivQ, tdivD;
    logic [7:0]  opQ, opD;
    logic [7:0]  lowOutQ, lowOutD;
    logic        lowOeQ, lowOeD;
    logic [7:0]  highQ, highD;
    logic        aleQ, aleD, psenQ, psenD, rdQ, rdD, tickQ, tickD, illQ, illD;
    logic [7:0]  in1Q, in2Q, in3Q, inStable;
    logic [7:0]  scratch [`CCT_SCRATCH_WORDS];
    logic [7:0]  scrQ;
    logic [3:0]  decCycles;
    logic        decMove, decValid;
    logic        cycEnd;

    cct_decode u_dec (
        .opcode     (inStable),
        .cycles     (decCycles),
        .isDataMove (decMove),
        .isValid    (decValid)
    );

    assign cycEnd = (phaseQ == `CCT_CLKS_PER_CYCLE);
    assign inStable = (in2Q == in3Q) ? in3Q : opQ;

    always_comb begin
        phaseD = phaseQ + 2'h1;
        stateD = stateQ;
        leftD = leftQ;
        pcD = pcQ;
        opD = opQ;
        illD = illQ;
        stretchD = stretchWrite ? stretchIn : stretchQ;
        tdivD = tdivQ + 4'h1;
        tickD = 1'b0;
        if (tdivQ >= (timerFast ? `CCT_FAST_TIMER_DIV : `CCT_SLOW_TIMER_DIV)) begin
            tdivD = 4'h0;
            tickD = 1'b1;
        end
        lowOutD = lowOutQ;
        lowOeD = lowOeQ;
        highD = highQ;
        psenD = 1'b1;
        rdD = 1'b1;
        case (stateQ)
            cct_pkg::CCT_IDLE: begin
                if (cycEnd) begin
                    stateD = cct_pkg::CCT_FETCH;
                    pcD = `CCT_RESET_PC;
                end
            end
            cct_pkg::CCT_FETCH: begin
                lowOutD = pcQ[7:0];
                highD = pcQ[15:8];
                lowOeD = (phaseQ >= 2'h1);
                psenD = (phaseQ < 2'h2);
                if (cycEnd) begin
                    opD = inStable;
                    illD = illQ | ~decValid;
                    pcD = pcQ + 16'h1;
                    if (decMove) begin
                        // fetch cycle already counts as the first of the move
                        leftD = `CCT_MOVE_BASE + {1'b0, stretchQ} - `CCT_CYC_TWO;
                        stateD = cct_pkg::CCT_DATA;
                    end else if (decCycles > `CCT_CYC_ONE) begin
                        leftD = decCycles - 4'h1 - 4'h1;
                        stateD = cct_pkg::CCT_EXEC;
                    end
                end
            end
            cct_pkg::CCT_EXEC: begin
                lowOutD = pcQ[7:0];
                highD = pcQ[15:8];
                if (cycEnd) begin
                    if (leftQ == 4'h0) begin
                        stateD = cct_pkg::CCT_FETCH;
                    end else begin
                        leftD = leftQ - 4'h1;
                    end
                end
            end
            cct_pkg::CCT_DATA: begin
                lowOutD = dataAddr[7:0];
                highD = dataAddr[15:8];
                lowOeD = 1'b1;
                rdD = 1'b0;
                if (cycEnd) begin
                    if (leftQ == 4'h0) begin
                        stateD = cct_pkg::CCT_FETCH;
                        rdD = 1'b1;
                    end else begin
                        leftD = leftQ - 4'h1;
                    end
                end
            end
            default: stateD = cct_pkg::CCT_IDLE;
        endcase
        // first fetch cycle gets its latch pulse too
        aleD = (phaseD == `CCT_ALE_PHASE) && stateD != cct_pkg::CCT_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stateQ <= cct_pkg::CCT_IDLE;
            phaseQ <= 2'h0;
            leftQ <= 4'h0;
            pcQ <= `CCT_RESET_PC;
            stretchQ <= `CCT_STRETCH_RESET;
            tdivQ <= 4'h0;
            opQ <= 8'h00;
            lowOutQ <= 8'h00;
            lowOeQ <= 1'b1;
            highQ <= 8'h00;
            aleQ <= 1'b0;
            psenQ <= 1'b1;
            rdQ <= 1'b1;
            tickQ <= 1'b0;
            illQ <= 1'b0;
            in1Q <= 8'h00;
            in2Q <= 8'h00;
            in3Q <= 8'h00;
        end else begin
            stateQ <= stateD;
            phaseQ <= phaseD;
            leftQ <= leftD;
            pcQ <= pcD;
            stretchQ <= stretchD;
            tdivQ <= tdivD;
            opQ <= opD;
            lowOutQ <= lowOutD;
            lowOeQ <= lowOeD;
            highQ <= highD;
            aleQ <= aleD;
            psenQ <= psenD;
            rdQ <= rdD;
            tickQ <= tickD;
            illQ <= illD;
            in1Q <= lowPortBusIn;
            in2Q <= in1Q;
            in3Q <= in2Q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (scratchWe) begin
            scratch[scratchAddr] <= scratchWdata;
        end
        scrQ <= scratch[scratchAddr];
    end

    // instruction semantics live in the datapath; timing is independent
    assign scratchRdata = scrQ;
    assign lowPortBusOut = lowOutQ;
    assign lowPortBusOe_n = lowOeQ;
    assign highPortBus = highQ;
    assign addrLatch = aleQ;
    assign progStrobe_n = psenQ;
    assign dataRead_n = rdQ;
    assign timerTick = tickQ;
    assign opcodeQ = opQ;
    assign illegalOp = illQ;

    a_ale_period: assert property (@(posedge sys_clk) disable iff (rst)
        addrLatch |=> !addrLatch [*3] ##1 addrLatch)
        else $error("address latch not once per four clocks");
    a_stretch_reset: assert property (@(posedge sys_clk)
        $fell(rst) |-> stretchQ == 3'h1)
        else $error("stretch not one after reset");
    a_first_fetch: assert property (@(posedge sys_clk)
        $fell(rst) |-> ##4 (stateQ == cct_pkg::CCT_FETCH && pcQ == 16'h0))
        else $error("first fetch not at zero");
    a_fetch_unstretched: assert property (@(posedge sys_clk) disable iff (rst)
        stateQ == cct_pkg::CCT_FETCH |-> dataRead_n || $past(stateQ) == cct_pkg::CCT_DATA)
        else $error("data strobe during fetch");
    a_move_length: assert property (@(posedge sys_clk) disable iff (rst)
        (stateQ == cct_pkg::CCT_FETCH && cycEnd && decMove)
        |=> leftQ == {1'b0, $past(stretchQ)})
        else $error("move length mismatch");
    a_phase_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        cycEnd |=> phaseQ == 2'h0)
        else $error("machine cycle not four clocks");
    a_tick_gap: assert property (@(posedge sys_clk) disable iff (rst)
        (timerTick && !timerFast) |=> (!timerTick || timerFast) [*8])
        else $error("slow timer ticks too early");
    a_high_addr: assert property (@(posedge sys_clk) disable iff (rst)
        (stateQ == cct_pkg::CCT_DATA && phaseQ == 2'h1) |-> highPortBus == dataAddr[15:8]
        || $changed(dataAddr))
        else $error("high address not driven");
endmodule
`default_nettype wire

//--- bench/cct_prog_mem.sv
// external program memory model answering opcode fetches
`timescale 1ns/1ps
`default_nettype none
module cct_prog_mem (
    input  wire logic       sys_clk,        // oscillator clock
    input  wire logic       rst,            // synchronous reset
    input  wire logic       lowPortBusOe_n, // core drives low port when low
    input  wire logic       progStrobe_n,   // fetch strobe
    output logic [7:0]      lowPortBusIn,   // opcode onto low port
    output int              fetchCount      // fetches completed
);
    logic [7:0] prog [64];
    logic       strobeQ;
    logic       addrSeenQ;
    // next byte stands from the previous strobe fall, ahead of the core's synchroniser
    assign lowPortBusIn = prog[fetchCount[5:0]];
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strobeQ <= 1'b1;
            addrSeenQ <= 1'b0;
            fetchCount <= 0;
        end else begin
            strobeQ <= progStrobe_n;
            if (!lowPortBusOe_n) begin
                addrSeenQ <= 1'b1;
            end else if (strobeQ && !progStrobe_n && addrSeenQ) begin
                addrSeenQ <= 1'b0;
                fetchCount <= fetchCount + 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/tb_core_cycle_timing.sv
// self-checking bench for the core cycle timing block
`timescale 1ns/1ps
`default_nettype none
module tb_core_cycle_timing;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  lowPortBusIn, lowPortBusOut, highPortBus, scratchRdata, opcodeQ;
    logic [7:0]  scratchAddr = 8'h00;
    logic [7:0]  scratchWdata = 8'h00;
    logic [2:0]  stretchIn = 3'h0;
    logic        stretchWrite = 1'b0;
    logic        timerFast = 1'b0;
    logic        scratchWe = 1'b0;
    logic [15:0] dataAddr = 16'h0000;
    logic        lowPortBusOe_n, addrLatch, progStrobe_n, dataRead_n, timerTick, illegalOp;
    int          fetchCount, g;
    int          miscompares = 0;
    int          n_compared = 0;
    int          sinceAle = 0;
    int          sinceFetch = 0;
    int          nFetch = 0;
    int          expQ[$];
    logic [7:0]  opQ[$];
    logic [7:0]  sAddr[4], sData[4];
    logic [7:0]  ops[18] = '{8'h00, 8'h24, 8'h85, 8'h90, 8'ha4, 8'h84, 8'h02, 8'h12, 8'h22,
                             8'h32, 8'hb4, 8'h20, 8'h01, 8'h80, 8'h11, 8'h40, 8'ha3, 8'h93};
    int          clks[18] = '{4, 8, 12, 12, 20, 20, 16, 16, 16, 16, 16, 16, 12, 12, 12, 12, 12, 12};
    bit          aleSeen = 1'b0;

    cct_core_timing DUT (.sys_clk(sys_clk), .rst(rst), .lowPortBusIn(lowPortBusIn),
        .stretchIn(stretchIn), .stretchWrite(stretchWrite), .timerFast(timerFast),
        .dataAddr(dataAddr), .scratchAddr(scratchAddr), .scratchWdata(scratchWdata),
        .scratchWe(scratchWe), .lowPortBusOut(lowPortBusOut), .lowPortBusOe_n(lowPortBusOe_n),
        .highPortBus(highPortBus), .addrLatch(addrLatch), .progStrobe_n(progStrobe_n),
        .dataRead_n(dataRead_n), .timerTick(timerTick), .scratchRdata(scratchRdata),
        .opcodeQ(opcodeQ), .illegalOp(illegalOp));
    cct_prog_mem mem (.sys_clk(sys_clk), .rst(rst), .lowPortBusOe_n(lowPortBusOe_n),
        .progStrobe_n(progStrobe_n), .lowPortBusIn(lowPortBusIn), .fetchCount(fetchCount));

    always #5 sys_clk = ~sys_clk;

    task automatic chk_count(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compared %0d, miscompared %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic put(input int i, input logic [7:0] op, input int c);
        mem.prog[i] = op;
        opQ.push_back(op);
        expQ.push_back(c);
    endtask

    // clocks from one timer tick to the next
    task automatic gap(output int n);
        n = 0;
        for (int i = 0; i < 200 && timerTick !== 1'b1; i++) @(negedge sys_clk);
        for (int i = 0; i < 200; i++) begin
            @(negedge sys_clk);
            n++;
            if (timerTick === 1'b1) break;
        end
    endtask

    // instruction length is the distance between fetch starts
    always @(negedge sys_clk) begin
        if (!rst) begin
            sinceAle++;
            sinceFetch++;
            if (addrLatch === 1'b1) begin
                if (aleSeen) chk_count(sinceAle, 4);
                aleSeen = 1'b1;
                sinceAle = 0;
            end
            if (dataRead_n === 1'b0) begin
                chk_byte(highPortBus, dataAddr[15:8]);
                chk_byte(lowPortBusOut, dataAddr[7:0]);
            end
            if (lowPortBusOe_n === 1'b0) begin
                if (nFetch == 0) begin
                    chk_byte(highPortBus, 8'h00);
                    chk_byte(lowPortBusOut, 8'h00);
                end else if (expQ.size() > 0) begin
                    chk_count(sinceFetch, expQ.pop_front());
                    chk_byte(opcodeQ, opQ.pop_front());
                    chk_byte({7'h00, illegalOp}, 8'h00);
                end
                nFetch++;
                sinceFetch = 0;
            end
        end
    end

    initial begin
        void'($urandom(32'hb38c7d94));
        dataAddr = 16'($urandom);
        for (int i = 0; i < 64; i++) mem.prog[i] = 8'h00;
        for (int i = 0; i < 18; i++) put(i, ops[i], clks[i]);
        put(18, 8'he0, 12);
        for (int s = 0; s < 8; s++) begin
            put(19 + 2 * s, 8'ha4, 20);
            put(20 + 2 * s, 8'he0, (2 + s) * 4);
        end
        mem.prog[35] = 8'ha5;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        fork
            for (int s = 0; s < 8; s++) begin
                for (int i = 0; i < 3000 && fetchCount < 20 + 2 * s; i++) @(negedge sys_clk);
                stretchIn = 3'(s);
                stretchWrite = 1'b1;
                @(negedge sys_clk);
                stretchWrite = 1'b0;
            end
            begin
                gap(g);
                gap(g);
                chk_count(g, 12);
                timerFast = 1'b1;
                gap(g);
                gap(g);
                chk_count(g, 4);
            end
            begin
                for (int i = 0; i < 4; i++) begin
                    sAddr[i] = 8'(i * 64) | 8'($urandom_range(63));
                    sData[i] = 8'($urandom);
                    scratchAddr = sAddr[i];
                    scratchWdata = sData[i];
                    scratchWe = 1'b1;
                    @(negedge sys_clk);
                end
                scratchWe = 1'b0;
                for (int i = 0; i < 4; i++) begin
                    scratchAddr = sAddr[i];
                    @(negedge sys_clk);
                    chk_byte(scratchRdata, sData[i]);
                end
            end
        join
        for (int i = 0; i < 5000 && fetchCount < 37; i++) @(negedge sys_clk);
        chk_count(expQ.size(), 0);
        chk_byte({7'h00, illegalOp}, 8'h01);
        close_out();
    end
endmodule
`default_nettype wire
